// *** rtl/irq_dispatch_pkg.sv ***
package irq_dispatch_pkg;

    // number of external request lines from the input module
    localparam int unsigned N_EXT = 4;
    // one extra source slot for the periodic scheduler
    localparam int unsigned N_SRC = N_EXT + 1;
    // index of the scheduled source within the pending vector
    localparam int unsigned SCHED_IDX = N_EXT;
    // width of a source index
    localparam int unsigned IDX_W = $clog2(N_SRC);

    // setup word layout and recognised values
    localparam int unsigned MODE_WORD_W = 16;
    localparam logic [MODE_WORD_W-1:0] MODE_NORMAL_VAL = 16'h0000;
    localparam logic [MODE_WORD_W-1:0] MODE_HIGH_VAL   = 16'h0001;

    // scheduler interval width, in clock cycles
    localparam int unsigned INTERVAL_W = 16;
    // reset values
    localparam logic [N_SRC-1:0] MASK_RST = '0;
    localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 16'h0000;

    // clock rate, kept for derivations elsewhere
    localparam int unsigned CLK_HZ = 25_000_000;

    // interrupt control function operations
    typedef enum logic [1:0] {
        CTL_NOP,
        CTL_SET_MASK,
        CTL_CLEAR,
        CTL_SCHED
    } ctl_op_e;

    // one control command: operation plus a per-source bit vector
    typedef struct packed {
        logic             valid;
        ctl_op_e          op;
        logic [N_SRC-1:0] bits;
    } ctl_cmd_s;

    // dispatch report toward the cpu sequencer
    typedef struct packed {
        logic             dispatch;
        logic             preempt;
        logic [IDX_W-1:0] vector;
    } dispatch_s;

    // interrupt mode held in the block
    typedef enum logic {
        MODE_NORMAL,
        MODE_HIGH
    } irq_mode_e;

endpackage

// *** rtl/req_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module req_sync #(
    parameter int unsigned WIDTH = 4
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_resetn,
    // asynchronous request pins
    input  wire logic [WIDTH-1:0] i_pin,
    // one-cycle rising-edge pulses
    output logic      [WIDTH-1:0] o_rise
);

    logic [WIDTH-1:0] meta_q;  // first stage, read only by sync_q
    logic [WIDTH-1:0] sync_q;  // second stage
    logic [WIDTH-1:0] last_q;  // previous synchronised level

    // two-stage synchroniser plus history for edge detect
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // edge pulse from the settled stages only
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            o_rise <= '0;
        end else begin
            o_rise <= sync_q & ~last_q;
        end
    end

endmodule // req_sync

`default_nettype wire

// *** rtl/sched_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module sched_timer #(
    parameter int unsigned WIDTH = 16
) (
    // clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_resetn,
    // run control and period in cycles (zero halts)
    input  wire logic             i_run,
    input  wire logic [WIDTH-1:0] i_period,
    // one-cycle pulse each period
    output logic                  o_tick
);

    logic [WIDTH-1:0] cnt_q;  // cycles elapsed in this period

    // free count while running, restart on each tick or stop
    always_ff @(posedge i_mclk) begin
        if (!i_resetn || !i_run || i_period == '0) begin
            cnt_q  <= '0;
            o_tick <= 1'b0;
        end else if (cnt_q >= i_period - WIDTH'(1)) begin
            cnt_q  <= '0;
            o_tick <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + WIDTH'(1);
            o_tick <= 1'b0;
        end
    end

endmodule // sched_timer

`default_nettype wire

// *** rtl/plc_interrupt_dispatch_control.sv ***
// Summary of operation
// RULE_01: control function governs input and scheduled interrupts
// RULE_02: masked requests still latch, never dispatch
// RULE_03: clear command discards pending requests
// RULE_04: two source classes: external and scheduled
// RULE_05: scheduled interrupt repeats at regular period
// RULE_06: normal mode waits for current process end
// RULE_07: high-speed mode preempts current process immediately
// RULE_08: reset gives normal mode; setup selects high-speed
// RULE_09: setup word zero selects normal mode
// RULE_10: normal mode lets servicing and instructions finish
// RULE_11: setup word one selects high-speed mode
// RULE_12: one pending latch per source, cleared on dispatch
`timescale 1ns/10ps
`default_nettype none

module plc_interrupt_dispatch_control
    import irq_dispatch_pkg::*;
#(
    parameter int unsigned INTERVAL_BITS = irq_dispatch_pkg::INTERVAL_W
) (
    // clock and reset
    input  wire logic                              i_mclk,
    input  wire logic                              i_resetn,
    // external request pins from the input interrupt module
    input  wire logic [irq_dispatch_pkg::N_EXT-1:0] i_ext_req,
    // interrupt control function command (same clock)
    input  wire irq_dispatch_pkg::ctl_cmd_s         i_ctl,
    input  wire logic [INTERVAL_BITS-1:0]           i_sched_period,
    // setup word and its load strobe (same clock)
    input  wire logic [irq_dispatch_pkg::MODE_WORD_W-1:0] i_mode_word,
    input  wire logic                              i_mode_load,
    // cpu activity: host link, remote io, special io, instruction
    input  wire logic [3:0]                        i_proc_busy,
    // service routine has returned
    input  wire logic                              i_isr_done,
    // dispatch report
    output irq_dispatch_pkg::dispatch_s            o_disp,
    // status
    output logic                                   o_in_service,
    output logic [irq_dispatch_pkg::N_SRC-1:0]     o_pending,
    output logic [irq_dispatch_pkg::N_SRC-1:0]     o_mask,
    output logic                                   o_high_speed
);

    import irq_dispatch_pkg::*;

    // dispatcher states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_SERVICE
    } disp_state_e;

    // pick lowest-numbered eligible source
    function automatic logic [IDX_W-1:0] first_set(
        input logic [N_SRC-1:0] v
    );
        logic [IDX_W-1:0] idx;
        idx = '0;
        // scan downward so the lowest index is written last
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = IDX_W'(i);
            end
        end
        return idx;
    endfunction

    // decode setup word into a mode; other values keep current mode
    function automatic irq_mode_e decode_mode(
        input logic [MODE_WORD_W-1:0] w,
        input irq_mode_e              cur
    );
        irq_mode_e m;
        m = cur;
        if (w == MODE_NORMAL_VAL) begin
            m = MODE_NORMAL;  // see RULE_09
        end else if (w == MODE_HIGH_VAL) begin
            m = MODE_HIGH;    // see RULE_11
        end
        return m;
    endfunction

    logic [N_EXT-1:0]         ext_rise;     // synchronised request edges
    logic                     sched_tick;   // periodic request pulse
    logic [N_SRC-1:0]         req_set;      // all request pulses
    logic [N_SRC-1:0]         pend_q;       // pending latches
    logic [N_SRC-1:0]         mask_q;       // mask bits
    logic                     sched_run_q;  // scheduler enabled
    irq_mode_e                mode_q;       // current interrupt mode
    disp_state_e              state_q;      // dispatcher state
    disp_state_e              state_d;      // next dispatcher state
    logic [N_SRC-1:0]         eligible;     // pending and not masked
    logic                     any_elig;     // some source may run
    logic [IDX_W-1:0]         pick;         // chosen source index
    logic                     proc_busy;    // a process is running
    logic                     fire;         // dispatch this cycle
    logic                     fire_pre;     // dispatch preempts cpu
    logic [N_SRC-1:0]         dispatch_clr; // pending bit taken now
    logic [N_SRC-1:0]         cmd_clr;      // pending bits cleared
    logic                     cmd_ok;       // valid control command

    // external pins pass two flops, then edge detect
    req_sync #(
        .WIDTH (N_EXT)
    ) u_sync (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_pin    (i_ext_req),
        .o_rise   (ext_rise)
    );

    // periodic request source, independent of the program flow
    sched_timer #(
        .WIDTH (INTERVAL_BITS)
    ) u_sched (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_run    (sched_run_q),
        .i_period (i_sched_period),
        .o_tick   (sched_tick)  // see RULE_05
    );

    // request vector: external sources low, scheduled source on top
    always_comb begin
        req_set            = '0;
        req_set[N_EXT-1:0] = ext_rise;    // see RULE_04
        req_set[SCHED_IDX] = sched_tick;  // see RULE_04
    end

    // control command decode
    always_comb begin
        cmd_ok  = i_ctl.valid;
        cmd_clr = '0;
        // only the clear op touches the pending latches
        if (cmd_ok && i_ctl.op == CTL_CLEAR) begin
            cmd_clr = i_ctl.bits;  // see RULE_03
        end
    end

    // mask register written by the control function
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            // nothing masked after power-up
            mask_q <= MASK_RST;
        end else if (cmd_ok && i_ctl.op == CTL_SET_MASK) begin
            mask_q <= i_ctl.bits;  // see RULE_01
        end
    end

    // scheduler run bit, governed by the control function
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            // scheduler stopped until commanded
            sched_run_q <= 1'b0;
        end else if (cmd_ok && i_ctl.op == CTL_SCHED) begin
            sched_run_q <= i_ctl.bits[SCHED_IDX];  // see RULE_01
        end
    end

    // mode register; normal after reset, changed only by setup load
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            // normal mode is the default
            mode_q <= MODE_NORMAL;  // see RULE_08
        end else if (i_mode_load) begin
            mode_q <= decode_mode(i_mode_word, mode_q);  // see RULE_08
        end
    end

    // eligibility ignores masked sources but they stay pending
    always_comb begin
        eligible  = pend_q & ~mask_q;  // see RULE_02
        any_elig  = |eligible;
        pick      = first_set(eligible);
        // busy while any of the four activities runs
        proc_busy = |i_proc_busy;
    end

    // dispatch decision per mode
    always_comb begin
        state_d  = state_q;
        fire     = 1'b0;
        fire_pre = 1'b0;
        // one transition per cycle
        unique case (state_q)
            ST_IDLE: begin
                if (any_elig) begin
                    if (mode_q == MODE_HIGH) begin
                        // interrupt whatever runs now
                        fire     = 1'b1;          // see RULE_07
                        fire_pre = proc_busy;     // see RULE_07
                        state_d  = ST_SERVICE;
                    end else if (!proc_busy) begin
                        // nothing in progress, go at once
                        fire    = 1'b1;
                        state_d = ST_SERVICE;
                    end else begin
                        // let the running process finish
                        state_d = ST_WAIT;        // see RULE_06
                    end
                end
            end
            ST_WAIT: begin
                if (!any_elig) begin
                    // cleared or masked while waiting
                    state_d = ST_IDLE;
                end else if (mode_q == MODE_HIGH) begin
                    fire     = 1'b1;              // see RULE_07
                    fire_pre = proc_busy;
                    state_d  = ST_SERVICE;
                end else if (!proc_busy) begin
                    // servicing or instruction has completed
                    fire    = 1'b1;               // see RULE_10
                    state_d = ST_SERVICE;
                end
            end
            ST_SERVICE: begin
                // routine runs until it returns
                if (i_isr_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                // unused state code, fall back to idle
                state_d = ST_IDLE;
            end
        endcase
    end

    // dispatcher state register
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            // no routine running after reset
            state_q <= ST_IDLE;
        end else begin
            // advance one step per cycle
            state_q <= state_d;
        end
    end

    // one-hot of the source handed to its routine
    always_comb begin
        dispatch_clr = '0;
        // nothing is taken without a dispatch
        if (fire) begin
            dispatch_clr[pick] = 1'b1;  // see RULE_12
        end
    end

    // pending latches: a new request wins over any clear
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            // no request recorded yet
            pend_q <= '0;
        end else begin
            // see RULE_12
            pend_q <= (pend_q & ~(cmd_clr | dispatch_clr)) | req_set;
        end
    end

    // dispatch report, registered
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            // no report, vector zero
            o_disp <= '0;
        end else begin
            // pulse for one cycle per dispatch
            o_disp.dispatch <= fire;
            o_disp.preempt  <= fire_pre;  // see RULE_07
            o_disp.vector   <= fire ? pick : o_disp.vector;
        end
    end

    // service flag follows the next state
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            // not in a routine
            o_in_service <= 1'b0;
        end else begin
            // early by one state so it lines up with the pulse
            o_in_service <= (state_d == ST_SERVICE);
        end
    end

    // status mirrors of internal state
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            // mirrors start at their reset values
            o_pending    <= '0;
            o_mask       <= MASK_RST;
            o_high_speed <= 1'b0;
        end else begin
            // one cycle behind the internal state
            o_pending    <= pend_q;
            o_mask       <= mask_q;
            o_high_speed <= (mode_q == MODE_HIGH);
        end
    end

endmodule // plc_interrupt_dispatch_control

`default_nettype wire

// *** bench/irq_dispatch_chk_sva.sv ***
`timescale 1ns/10ps
`default_nettype none

// checker on the dispatch block's ports
module irq_dispatch_chk
    import irq_dispatch_pkg::*;
#(
    parameter int unsigned INTERVAL_BITS = INTERVAL_W
) (
    // clock and reset
    input wire logic                     i_mclk,
    input wire logic                     i_resetn,
    // requests, control, setup
    input wire logic [N_EXT-1:0]         i_ext_req,
    input wire ctl_cmd_s                 i_ctl,
    input wire logic [INTERVAL_BITS-1:0] i_sched_period,
    input wire logic [MODE_WORD_W-1:0]   i_mode_word,
    input wire logic                     i_mode_load,
    input wire logic [3:0]               i_proc_busy,
    input wire logic                     i_isr_done,
    // outputs watched
    input wire dispatch_s                o_disp,
    input wire logic                     o_in_service,
    input wire logic [N_SRC-1:0]         o_pending,
    input wire logic [N_SRC-1:0]         o_mask,
    input wire logic                     o_high_speed
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    // setup word one turns high-speed on
    property p_load_high;
        i_mode_load && i_mode_word == MODE_HIGH_VAL |-> ##[1:2] o_high_speed;
    endproperty
    a_load_high: assert property (p_load_high)
        else $error("high-speed not entered");
    // setup word zero turns it off
    property p_load_norm;
        i_mode_load && i_mode_word == MODE_NORMAL_VAL |-> ##[1:2] !o_high_speed;
    endproperty
    a_load_norm: assert property (p_load_norm)
        else $error("normal mode not entered");
    // any other word leaves the mode alone
    property p_mode_other;
        i_mode_load && i_mode_word > MODE_HIGH_VAL |=> $stable(o_high_speed)[*2];
    endproperty
    a_mode_other: assert property (p_mode_other)
        else $error("mode changed by unknown word");
    // a masked source is never dispatched
    property p_masked;
        o_disp.dispatch |-> !o_mask[o_disp.vector];
    endproperty
    a_masked: assert property (p_masked)
        else $error("masked source dispatched");
    // dispatch comes from a pending latch and starts service
    property p_pend_hit;
        o_disp.dispatch |-> o_pending[o_disp.vector] && o_in_service;
    endproperty
    a_pend_hit: assert property (p_pend_hit)
        else $error("dispatch without pending latch");
    // normal mode waits for all activity to end
    property p_defer;
        o_disp.dispatch && !o_high_speed |-> $past(i_proc_busy) == 4'h0;
    endproperty
    a_defer: assert property (p_defer)
        else $error("dispatch while busy in normal mode");
    // high-speed mode preempts a busy process
    property p_preempt;
        o_disp.dispatch && o_high_speed && $past(i_proc_busy) != 4'h0
            |-> o_disp.preempt;
    endproperty
    a_preempt: assert property (p_preempt)
        else $error("busy process not preempted");
    // preempt only flags a high-speed dispatch
    property p_pre_high;
        o_disp.preempt |-> o_disp.dispatch && o_high_speed;
    endproperty
    a_pre_high: assert property (p_pre_high)
        else $error("preempt outside high-speed dispatch");
    // clear empties the named external latches
    property p_clear;
        i_ctl.valid && i_ctl.op == CTL_CLEAR |->
            ##2 (o_pending[N_EXT-1:0] & $past(i_ctl.bits[N_EXT-1:0], 2)) == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("pending not cleared");
    // set-mask loads the mask
    property p_mask_load;
        i_ctl.valid && i_ctl.op == CTL_SET_MASK
            |-> ##2 o_mask == $past(i_ctl.bits, 2);
    endproperty
    a_mask_load: assert property (p_mask_load)
        else $error("mask not loaded");

    // main scenarios
    c_preempt: cover property (o_disp.dispatch && o_disp.preempt);
    c_sched: cover property (o_disp.dispatch && o_disp.vector == SCHED_IDX);
    c_normal: cover property (o_disp.dispatch && !o_high_speed);
endmodule // irq_dispatch_chk

bind plc_interrupt_dispatch_control irq_dispatch_chk #(
    .INTERVAL_BITS(INTERVAL_BITS)
) chk_u (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ext_req(i_ext_req),
    .i_ctl(i_ctl), .i_sched_period(i_sched_period),
    .i_mode_word(i_mode_word), .i_mode_load(i_mode_load),
    .i_proc_busy(i_proc_busy), .i_isr_done(i_isr_done), .o_disp(o_disp),
    .o_in_service(o_in_service), .o_pending(o_pending), .o_mask(o_mask),
    .o_high_speed(o_high_speed)
);

`default_nettype wire

// *** bench/irq_input_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// input interrupt module: stretches each strobe into a pin pulse
module irq_input_model
    import irq_dispatch_pkg::*;
#(
    parameter int unsigned HOLD = 4
) (
    // clock
    input  wire logic             i_mclk,
    // bench strobes, one per line
    input  wire logic [N_EXT-1:0] i_fire,
    // request pins toward the block
    output logic      [N_EXT-1:0] o_pin
);
    logic [N_EXT-1:0][2:0] cnt_q = '0; // remaining high cycles

    // long enough to pass the synchroniser
    always_ff @(posedge i_mclk) begin
        for (int k = 0; k < N_EXT; k++) begin
            if (i_fire[k]) begin
                cnt_q[k] <= 3'(HOLD);
            end else if (cnt_q[k] != 3'h0) begin
                cnt_q[k] <= cnt_q[k] - 3'h1;
            end
        end
    end
    // each pin is one external source
    always_comb begin
        for (int k = 0; k < N_EXT; k++) begin
            o_pin[k] = (cnt_q[k] != 3'h0);
        end
    end
endmodule // irq_input_model

`default_nettype wire

// *** bench/plc_interrupt_dispatch_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end

module plc_interrupt_dispatch_control_tb;
    import irq_dispatch_pkg::*;
    localparam int PER = 20; // short scheduler period
    logic i_mclk = 1'b0, i_resetn = 1'b0, mode_load = 1'b0, isr_done = 1'b0;
    logic [N_EXT-1:0] fire = '0, ext_req;
    ctl_cmd_s ctl = '0;
    logic [15:0] period = '0, mode_word = '0;
    logic [3:0] busy = '0;
    dispatch_s disp;
    logic in_service, high;
    logic [N_SRC-1:0] pending, mask;
    int errors = 0, checked = 0, n;

    // 25 MHz clock
    always #20 i_mclk = ~i_mclk;

    irq_input_model src_u (.i_mclk(i_mclk), .i_fire(fire), .o_pin(ext_req));
    plc_interrupt_dispatch_control dut_u (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ext_req(ext_req),
        .i_ctl(ctl), .i_sched_period(period), .i_mode_word(mode_word),
        .i_mode_load(mode_load), .i_proc_busy(busy), .i_isr_done(isr_done),
        .o_disp(disp), .o_in_service(in_service), .o_pending(pending),
        .o_mask(mask), .o_high_speed(high)
    );

    task automatic give_verdict();
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_mclk);
    endtask
    // one control command
    task automatic send(input ctl_op_e op, input logic [N_SRC-1:0] b);
        @(negedge i_mclk) ctl = '{1'b1, op, b};
        @(negedge i_mclk) ctl.valid = 1'b0;
    endtask
    task automatic pulse(input logic [N_EXT-1:0] b);
        @(negedge i_mclk) fire = b;
        @(negedge i_mclk) fire = '0;
    endtask
    task automatic load_mode(input logic [15:0] w);
        @(negedge i_mclk) mode_word = w;
        mode_load = 1'b1;
        @(negedge i_mclk) mode_load = 1'b0;
        cyc(3);
    endtask
    task automatic no_disp(input int k);
        repeat (k) begin
            @(negedge i_mclk);
            `CHK("no dispatch", 1'b0, disp.dispatch)
        end
    endtask
    // wait for a dispatch, judge it, return from the routine
    task automatic serve(input int v, input bit p, input int lim,
                         output int w);
        w = 0;
        while (disp.dispatch !== 1'b1) begin
            if (w == lim) begin
                errors++;
                $display("BAD dispatch exp 1 got 0");
                give_verdict();
            end
            @(negedge i_mclk);
            w++;
        end
        `CHK("vector", IDX_W'(v), disp.vector)
        `CHK("preempt", p, disp.preempt)
        `CHK("in service", 1'b1, in_service)
        isr_done = 1'b1;
        @(negedge i_mclk) isr_done = 1'b0;
        // back to idle; a queued source may fire on the next edge
        `CHK("in service", 1'b0, in_service)
    endtask

    task automatic t_reset();
        `CHK("mode", 1'b0, high)
        `CHK("mask", 5'h00, mask)
    endtask
    task automatic t_normal();
        for (int b = 0; b < 4; b++) begin
            busy = 4'(1 << b);
            pulse(4'h2);
            no_disp(12);
            `CHK("pending", 1'b1, pending[1])
            busy = 4'h0;
            serve(1, 1'b0, 6, n);
        end
    endtask
    task automatic t_mask();
        send(CTL_SET_MASK, 5'h05);
        pulse(4'h5);
        no_disp(12);
        `CHK("pending", 5'h05, pending)
        send(CTL_SET_MASK, 5'h00);
        serve(0, 1'b0, 8, n);
        serve(2, 1'b0, 8, n);
        `CHK("pending", 5'h00, pending)
    endtask
    task automatic t_clear();
        send(CTL_SET_MASK, 5'h08);
        pulse(4'h8);
        cyc(10);
        `CHK("pending", 1'b1, pending[3])
        send(CTL_CLEAR, 5'h08);
        cyc(3);
        `CHK("pending", 5'h00, pending)
        send(CTL_SET_MASK, 5'h00);
        no_disp(10);
    endtask
    task automatic t_high();
        load_mode(16'h0001);
        `CHK("mode", 1'b1, high)
        busy = 4'h2;
        pulse(4'h1);
        serve(0, 1'b1, 10, n);
        busy = 4'h0;
        load_mode(16'h0005);
        `CHK("mode", 1'b1, high)
        load_mode(16'h0000);
        `CHK("mode", 1'b0, high)
    endtask
    task automatic t_sched();
        period = 16'(PER);
        send(CTL_SCHED, 5'h10);
        serve(SCHED_IDX, 1'b0, PER + 8, n);
        repeat (2) begin
            serve(SCHED_IDX, 1'b0, PER + 8, n);
            `CHK("interval", PER, n + 1)
        end
        send(CTL_SCHED, 5'h00);
        no_disp(PER * 2);
    endtask

    initial begin
        cyc(6);
        i_resetn = 1'b1;
        cyc(2);
        t_reset();
        t_normal();
        t_mask();
        t_clear();
        t_high();
        t_sched();
        give_verdict();
    end
endmodule // plc_interrupt_dispatch_control_tb

`default_nettype wire
